// ### verilog/mua_cfg.svh
// Offsets, field positions and constants of the unary ALU block
`ifndef MUA_CFG_SVH
`define MUA_CFG_SVH
`define MUA_OFS_CMD 8'h00
`define MUA_OFS_WREG 8'h04
`define MUA_OFS_STATUS 8'h08
`define MUA_OFS_MADDR 8'h0c
`define MUA_OFS_MDATA 8'h10
`define MUA_OFS_WDT 8'h14
`define MUA_CMD_OP_LSB 0
`define MUA_CMD_ADR_LSB 8
`define MUA_ST_ZERO 0
`define MUA_ST_HC 1
`define MUA_ST_OV 2
`define MUA_ST_TO 3
`define MUA_ST_PDF 4
`define MUA_ST_SLEEP 5
`define MUA_WDT_EN 0
`define MUA_WDT_PRE_LSB 8
`define MUA_WDT_CNT_LSB 16
`define MUA_BYTE_ZERO 8'h00
`define MUA_BYTE_ONE 8'h01
`define MUA_BCD_LIMIT 4'h9
`define MUA_BCD_FIX 4'h6
`define MUA_NIB_ZERO 4'h0
`define MUA_WORD_ZERO 32'h0000_0000
`endif

// ### verilog/mua_pkg.sv
// Types shared by the unary ALU block
`default_nettype none
package mua_pkg;
	// Operation codes written to the command register
	typedef enum logic [3:0] {
		MUA_OP_NOP = 4'h0,
		MUA_OP_INV_MEM = 4'h1,
		MUA_OP_INV_WK = 4'h2,
		MUA_OP_BCD = 4'h3,
		MUA_OP_DEC_MEM = 4'h4,
		MUA_OP_DEC_WK = 4'h5,
		MUA_OP_INC_MEM = 4'h6,
		MUA_OP_INC_WK = 4'h7,
		MUA_OP_PWRDN = 4'h8,
		MUA_OP_WAKE = 4'h9,
		MUA_OP_KICK = 4'ha
	} mua_op_t;
	// Bus handshake states, Gray coded
	typedef enum logic [1:0] {
		MUA_IDLE = 2'b00,
		MUA_ACK = 2'b01
	} mua_bus_t;
endpackage
`default_nettype wire

// ### verilog/mua_alu.sv
// Unary ALU operations, power-down and watchdog with an Avalon-MM register port
//
// Summary of operation
// - Invert memory byte in place, update zero
// - Inverted memory byte into working register
// - Low nibble above 9 or half-carry: add 6
// - High nibble above 9 or overflow: add 6
// - Adjusted working register written to memory byte
// - Decimal adjust only sets overflow on carry
// - Decrement memory byte in place, update zero
// - Decremented byte into working register only
// - Power-down halts operations, keeps memory, working register and ALU flags
// - Power-down clears watchdog counter and prescaler
// - Power-down sets sleep flag, clears expired flag
// - Increment memory byte in place, update zero
`timescale 1ns/1ps
`default_nettype none
`include "mua_cfg.svh"
module mua_alu
	import mua_pkg::*;
#(
	parameter int MEM_AW = 4,
	parameter int PRE_W = 8,
	parameter int WDT_W = 8
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic ref_clk_en,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic sleeping
);
	// Bus handshake state
	mua_bus_t bus_q, bus_d;
	logic wait_q, wait_d;
	logic [31:0] rdata_q, rdata_d;
	logic [31:0] rmux;
	logic commit;

	// Core state
	logic [7:0] mem_q [0:(1<<MEM_AW)-1];
	logic [7:0] wreg_q, wreg_d;
	logic [MEM_AW-1:0] maddr_q, maddr_d;
	logic zero_q, zero_d, hc_q, hc_d, ov_q, ov_d;
	logic to_q, to_d, pdf_q, pdf_d, sleep_q, sleep_d;
	logic wdt_en_q, wdt_en_d;
	logic [PRE_W-1:0] pre_q, pre_d;
	logic [WDT_W-1:0] wdt_q, wdt_d;
	logic mem_we;
	logic [MEM_AW-1:0] mem_wa;
	logic [7:0] mem_wd;

	// Command decode and operand fetch
	mua_op_t op;
	logic [MEM_AW-1:0] op_addr;
	logic [7:0] mem_rd;
	logic lo_fix, hi_fix;
	logic [8:0] bcd_sum;
	logic expire, halting;
	logic [7:0] res;

	assign op = mua_op_t'(avs_writedata[`MUA_CMD_OP_LSB +: 4]);
	assign op_addr = avs_writedata[`MUA_CMD_ADR_LSB +: MEM_AW];
	assign mem_rd = mem_q[op_addr];
	// Write takes effect on the edge where waitrequest is sampled low
	assign commit = (bus_q == MUA_ACK) && avs_write;

	// Decimal adjust: corrections chosen from nibbles and flags
	assign lo_fix = (wreg_q[3:0] > `MUA_BCD_LIMIT) || hc_q;
	assign hi_fix = (wreg_q[7:4] > `MUA_BCD_LIMIT) || ov_q;
	assign bcd_sum = {1'b0, wreg_q} + {1'b0, (hi_fix ? `MUA_BCD_FIX : `MUA_NIB_ZERO),
		(lo_fix ? `MUA_BCD_FIX : `MUA_NIB_ZERO)};

	// Read multiplexer, unmapped offsets read as zero
	always_comb begin
		rmux = `MUA_WORD_ZERO;
		case (avs_address)
			`MUA_OFS_WREG: rmux[7:0] = wreg_q;
			`MUA_OFS_STATUS: begin
				rmux[`MUA_ST_ZERO] = zero_q;
				rmux[`MUA_ST_HC] = hc_q;
				rmux[`MUA_ST_OV] = ov_q;
				rmux[`MUA_ST_TO] = to_q;
				rmux[`MUA_ST_PDF] = pdf_q;
				rmux[`MUA_ST_SLEEP] = sleep_q;
			end
			`MUA_OFS_MADDR: rmux[MEM_AW-1:0] = maddr_q;
			`MUA_OFS_MDATA: rmux[7:0] = mem_q[maddr_q];
			`MUA_OFS_WDT: begin
				rmux[`MUA_WDT_EN] = wdt_en_q;
				rmux[`MUA_WDT_PRE_LSB +: PRE_W] = pre_q;
				rmux[`MUA_WDT_CNT_LSB +: WDT_W] = wdt_q;
			end
			default: rmux = `MUA_WORD_ZERO;
		endcase
	end

	// Bus handshake: one wait cycle, then one cycle with waitrequest low
	always_comb begin
		bus_d = bus_q;
		wait_d = 1'b1;
		rdata_d = rdata_q;
		case (bus_q)
			MUA_IDLE: if (avs_read || avs_write) begin
				bus_d = MUA_ACK;
				wait_d = 1'b0;
				rdata_d = avs_read ? rmux : `MUA_WORD_ZERO;
			end
			MUA_ACK: bus_d = MUA_IDLE;
			default: bus_d = MUA_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			bus_q <= MUA_IDLE;
			wait_q <= 1'b1;
			rdata_q <= `MUA_WORD_ZERO;
		end else if (ref_clk_en) begin
			bus_q <= bus_d;
			wait_q <= wait_d;
			rdata_q <= rdata_d;
		end
	end

	// Core next state: watchdog first, then commands, so power-down wins
	always_comb begin
		wreg_d = wreg_q;
		maddr_d = maddr_q;
		zero_d = zero_q;
		hc_d = hc_q;
		ov_d = ov_q;
		to_d = to_q;
		pdf_d = pdf_q;
		sleep_d = sleep_q;
		wdt_en_d = wdt_en_q;
		pre_d = pre_q;
		wdt_d = wdt_q;
		mem_we = 1'b0;
		mem_wa = op_addr;
		mem_wd = mem_rd;
		expire = 1'b0;
		halting = 1'b0;
		res = `MUA_BYTE_ZERO;
		// Watchdog keeps running while asleep so expiry can wake the core
		if (wdt_en_q) begin
			pre_d = pre_q + PRE_W'(1);
			if (&pre_q) begin
				wdt_d = wdt_q + WDT_W'(1);
				expire = &wdt_q;
			end
		end
		if (commit) begin
			case (avs_address)
				`MUA_OFS_CMD: if (!sleep_q || op == MUA_OP_WAKE) begin
					case (op)
						MUA_OP_INV_MEM: begin
							res = ~mem_rd;
							mem_we = 1'b1;
							mem_wd = res;
							zero_d = (res == `MUA_BYTE_ZERO);
						end
						MUA_OP_INV_WK: begin
							res = ~mem_rd;
							wreg_d = res;
							zero_d = (res == `MUA_BYTE_ZERO);
						end
						MUA_OP_BCD: begin
							mem_we = 1'b1;
							mem_wd = bcd_sum[7:0];
							if (bcd_sum[8]) begin
								ov_d = 1'b1;
							end
						end
						MUA_OP_DEC_MEM: begin
							res = mem_rd - `MUA_BYTE_ONE;
							mem_we = 1'b1;
							mem_wd = res;
							zero_d = (res == `MUA_BYTE_ZERO);
						end
						MUA_OP_DEC_WK: begin
							res = mem_rd - `MUA_BYTE_ONE;
							wreg_d = res;
							zero_d = (res == `MUA_BYTE_ZERO);
						end
						MUA_OP_INC_MEM: begin
							res = mem_rd + `MUA_BYTE_ONE;
							mem_we = 1'b1;
							mem_wd = res;
							zero_d = (res == `MUA_BYTE_ZERO);
						end
						MUA_OP_INC_WK: begin
							res = mem_rd + `MUA_BYTE_ONE;
							wreg_d = res;
							zero_d = (res == `MUA_BYTE_ZERO);
						end
						MUA_OP_PWRDN: begin
							halting = 1'b1;
							sleep_d = 1'b1;
							pre_d = '0;
							wdt_d = '0;
							pdf_d = 1'b1;
							to_d = 1'b0;
						end
						MUA_OP_WAKE: sleep_d = 1'b0;
						MUA_OP_KICK: begin
							pre_d = '0;
							wdt_d = '0;
						end
						default: res = `MUA_BYTE_ZERO;
					endcase
				end
				`MUA_OFS_WREG: wreg_d = avs_writedata[7:0];
				`MUA_OFS_STATUS: begin
					zero_d = avs_writedata[`MUA_ST_ZERO];
					hc_d = avs_writedata[`MUA_ST_HC];
					ov_d = avs_writedata[`MUA_ST_OV];
					to_d = avs_writedata[`MUA_ST_TO];
					pdf_d = avs_writedata[`MUA_ST_PDF];
				end
				`MUA_OFS_MADDR: maddr_d = avs_writedata[MEM_AW-1:0];
				`MUA_OFS_MDATA: begin
					mem_we = 1'b1;
					mem_wa = maddr_q;
					mem_wd = avs_writedata[7:0];
				end
				`MUA_OFS_WDT: wdt_en_d = avs_writedata[`MUA_WDT_EN];
				default: res = `MUA_BYTE_ZERO;
			endcase
		end
		// Expiry beats a software clear, but not a power-down in the same cycle
		if (expire && !halting) begin
			to_d = 1'b1;
			sleep_d = 1'b0;
		end
	end

	// Memory has no reset: contents survive power-down and reset alike
	always_ff @(posedge ref_clk) begin
		if (ref_clk_en && mem_we) begin
			mem_q[mem_wa] <= mem_wd;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wreg_q <= `MUA_BYTE_ZERO;
			maddr_q <= '0;
			zero_q <= 1'b0;
			hc_q <= 1'b0;
			ov_q <= 1'b0;
			to_q <= 1'b0;
			pdf_q <= 1'b0;
			sleep_q <= 1'b0;
			wdt_en_q <= 1'b0;
			pre_q <= '0;
			wdt_q <= '0;
		end else if (ref_clk_en) begin
			wreg_q <= wreg_d;
			maddr_q <= maddr_d;
			zero_q <= zero_d;
			hc_q <= hc_d;
			ov_q <= ov_d;
			to_q <= to_d;
			pdf_q <= pdf_d;
			sleep_q <= sleep_d;
			wdt_en_q <= wdt_en_d;
			pre_q <= pre_d;
			wdt_q <= wdt_d;
		end
	end

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign sleeping = sleep_q;

	// Checks
	logic fire;
	logic [3:0] wlo, whi;
	logic [7:0] at_op;
	assign fire = commit && ref_clk_en && (avs_address == `MUA_OFS_CMD) && !sleep_q;
	assign wlo = wreg_q[3:0];
	assign whi = wreg_q[7:4];
	assign at_op = mem_q[op_addr];

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence s_op(mua_op_t o);
		fire && op == o;
	endsequence

	AST_INV_MEM: assert property (s_op(MUA_OP_INV_MEM) |=> mem_q[$past(op_addr)] == ~$past(at_op)
		&& zero_q == ($past(at_op) == 8'hff)) else $error("invert to memory wrong");
	AST_INV_WK: assert property (s_op(MUA_OP_INV_WK) |=> wreg_q == ~$past(at_op)
		&& mem_q[$past(op_addr)] == $past(at_op)) else $error("invert to working wrong");
	AST_BCD_LO: assert property (s_op(MUA_OP_BCD) && wlo <= 4'h9 && !hc_q
		|=> mem_q[$past(op_addr)][3:0] == $past(wlo)) else $error("low nibble changed");
	AST_BCD_HI: assert property (s_op(MUA_OP_BCD) && (whi > 4'h9 || ov_q) && wlo <= 4'h9 && !hc_q
		|=> mem_q[$past(op_addr)][7:4] == $past(whi) + 4'h6) else $error("high nibble not fixed");
	AST_BCD_FIX: assert property (s_op(MUA_OP_BCD) && (wlo > 4'h9 || hc_q)
		|=> mem_q[$past(op_addr)][3:0] == $past(wlo) + 4'h6) else $error("low nibble not fixed");
	AST_BCD_FLAGS: assert property (s_op(MUA_OP_BCD) |=> $stable(zero_q) && $stable(hc_q)
		&& (ov_q == ($past(ov_q) || $past(bcd_sum[8])))) else $error("adjust flags wrong");
	AST_DEC_MEM: assert property (s_op(MUA_OP_DEC_MEM) && at_op == 8'h00
		|=> mem_q[$past(op_addr)] == 8'hff && !zero_q) else $error("decrement wrap wrong");
	AST_DEC_WK: assert property (s_op(MUA_OP_DEC_WK) |=> wreg_q == $past(at_op) - 8'h01
		&& mem_q[$past(op_addr)] == $past(at_op)) else $error("decrement to working wrong");
	AST_INC_MEM: assert property (s_op(MUA_OP_INC_MEM) |=>
		mem_q[$past(op_addr)] == $past(at_op) + 8'h01) else $error("increment wrong");
	AST_INC_ZERO: assert property (s_op(MUA_OP_INC_MEM) && at_op == 8'hff |=> zero_q)
		else $error("zero flag not set on wrap");
	AST_HALT: assert property (s_op(MUA_OP_PWRDN) |=> sleep_q && pdf_q && !to_q
		&& pre_q == '0 && wdt_q == '0) else $error("power-down effects wrong");
	// Compared one cycle after the ignored command, so a result that did land would show
	AST_ASLEEP: assert property (sleep_q && commit && ref_clk_en && avs_address == `MUA_OFS_CMD
		&& op != MUA_OP_WAKE |=> $stable(wreg_q) && $stable(zero_q)
		&& mem_q[$past(op_addr)] == $past(at_op)) else $error("op ran while asleep");
endmodule
`default_nettype wire

// ### bench/mua_seq.sv
// Register-bus master standing in for the core's instruction sequencer
`timescale 1ns/1ps
`default_nettype none
module mua_seq (
	input wire logic ref_clk,
	output logic [7:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	// Bus idle at time zero
	initial begin
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
	end
	// One access; request held until waitrequest is sampled low, so a slow answer is never cut short
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		avs_writedata <= ~wd; // Stale data never looks valid
	endtask
endmodule
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the unary ALU block
`timescale 1ns/1ps
`default_nettype none
`include "mua_cfg.svh"
module testbench;
	import mua_pkg::*;
	logic ref_clk, reset, ref_clk_en, avs_read, avs_write, avs_waitrequest, sleeping;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	int fails, n_checks;
	logic [9:0] bcd_in [7] = '{10'h045, 10'h04b, 10'h138, 10'h0a2, 10'h212, 10'h39a, 10'h099};
	logic [7:0] fix;
	logic [8:0] s;
	// Short watchdog widths keep expiry near 16 clocks
	mua_alu #(.MEM_AW(4), .PRE_W(2), .WDT_W(2)) i_dut (.ref_clk(ref_clk), .reset(reset),
		.ref_clk_en(ref_clk_en), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.sleeping(sleeping));
	mua_seq i_seq (.ref_clk(ref_clk), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	// 50 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		i_seq.xfer(1'b1, a, d, x);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		i_seq.xfer(1'b0, a, 32'h0000_0000, x);
		chk(x, e);
	endtask
	task automatic op(input logic [3:0] c, input logic [3:0] a);
		wr(`MUA_OFS_CMD, {20'h00000, a, 4'h0, c});
	endtask
	task automatic setm(input logic [3:0] a, input logic [7:0] v);
		wr(`MUA_OFS_MADDR, {28'h0000000, a});
		wr(`MUA_OFS_MDATA, {24'h000000, v});
	endtask
	task automatic memc(input logic [3:0] a, input logic [7:0] e);
		wr(`MUA_OFS_MADDR, {28'h0000000, a});
		rc(`MUA_OFS_MDATA, {24'h000000, e});
	endtask
	task automatic print_verdict;
		if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Hang guard: the whole sequence needs well under 1000 clocks
	initial begin
		repeat (4000) @(posedge ref_clk);
		fails++;
		print_verdict();
	end
	// Main sequence
	initial begin
		reset = 1'b1;
		ref_clk_en = 1'b1;
		fails = 0;
		n_checks = 0;
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		rc(`MUA_OFS_STATUS, 32'h0);
		rc(`MUA_OFS_CMD, 32'h0);
		rc(8'h1c, 32'h0);
		setm(4'h3, 8'hff);
		op(MUA_OP_INV_MEM, 4'h3);
		memc(4'h3, 8'h00);
		rc(`MUA_OFS_STATUS, 32'h1);
		op(MUA_OP_INV_MEM, 4'h3);
		memc(4'h3, 8'hff);
		rc(`MUA_OFS_STATUS, 32'h0);
		setm(4'h5, 8'h5a);
		op(MUA_OP_INV_WK, 4'h5);
		rc(`MUA_OFS_WREG, 32'ha5);
		memc(4'h5, 8'h5a);
		// Decrement through zero wraps to all ones
		setm(4'h1, 8'h00);
		op(MUA_OP_DEC_MEM, 4'h1);
		memc(4'h1, 8'hff);
		setm(4'h1, 8'h01);
		op(MUA_OP_DEC_MEM, 4'h1);
		memc(4'h1, 8'h00);
		rc(`MUA_OFS_STATUS, 32'h1);
		setm(4'h2, 8'h00);
		op(MUA_OP_DEC_WK, 4'h2);
		rc(`MUA_OFS_WREG, 32'hff);
		memc(4'h2, 8'h00);
		rc(`MUA_OFS_STATUS, 32'h0);
		setm(4'h6, 8'hff);
		op(MUA_OP_INC_MEM, 4'h6);
		memc(4'h6, 8'h00);
		rc(`MUA_OFS_STATUS, 32'h1);
		setm(4'h8, 8'h7f);
		op(MUA_OP_INC_WK, 4'h8);
		rc(`MUA_OFS_WREG, 32'h80);
		memc(4'h8, 8'h7f);
		rc(`MUA_OFS_STATUS, 32'h0);
		// Decimal adjust: zero flag preset so any stray flag change shows
		foreach (bcd_in[i]) begin
			wr(`MUA_OFS_STATUS, {29'h0, bcd_in[i][9:8], 1'b1});
			wr(`MUA_OFS_WREG, {24'h0, bcd_in[i][7:0]});
			op(MUA_OP_BCD, 4'h7);
			fix[7:4] = (bcd_in[i][7:4] > 4'h9 || bcd_in[i][9]) ? 4'h6 : 4'h0;
			fix[3:0] = (bcd_in[i][3:0] > 4'h9 || bcd_in[i][8]) ? 4'h6 : 4'h0;
			s = {1'b0, bcd_in[i][7:0]} + {1'b0, fix};
			memc(4'h7, s[7:0]);
			rc(`MUA_OFS_STATUS, {29'h0, bcd_in[i][9] | s[8], bcd_in[i][8], 1'b1});
		end
		// Let the watchdog count, then stop it before it can expire
		wr(`MUA_OFS_WDT, 32'h1);
		// Clock enable low must freeze the watchdog well past its expiry span
		ref_clk_en <= 1'b0;
		repeat (20) @(posedge ref_clk);
		ref_clk_en <= 1'b1;
		rc(`MUA_OFS_WDT, 32'h0000_0101);
		repeat (6) @(posedge ref_clk);
		wr(`MUA_OFS_WDT, 32'h0);
		wr(`MUA_OFS_STATUS, 32'h0f);
		wr(`MUA_OFS_WREG, 32'h3c);
		setm(4'h4, 8'h10);
		op(MUA_OP_PWRDN, 4'h0);
		// The flag is launched at the edge the task returns on; look one edge later
		@(posedge ref_clk);
		chk({31'h0, sleeping}, 32'h1);
		rc(`MUA_OFS_STATUS, 32'h37);
		rc(`MUA_OFS_WDT, 32'h0);
		op(MUA_OP_INC_MEM, 4'h4);
		memc(4'h4, 8'h10);
		op(MUA_OP_DEC_WK, 4'h4);
		rc(`MUA_OFS_WREG, 32'h3c);
		op(MUA_OP_WAKE, 4'h0);
		@(posedge ref_clk);
		chk({31'h0, sleeping}, 32'h0);
		op(MUA_OP_INC_MEM, 4'h4);
		memc(4'h4, 8'h11);
		print_verdict();
	end
endmodule
`default_nettype wire
